// ===== design/gate_drive_pkg.sv
// constants, register map and enumerations for the gate drive protection block
// How it works
// - saturation_sense, overcurrent or short fault starts two-step or soft shutdown per config
// - two-step holds gate at plateau level for plateau duration, then off
// - plateau level and plateau duration are software registers
// - after plateau, discharge with soft current if enabled, else normal sink
// - soft shutdown uses programmed sink level, selectable per fault class
// - clamp sense at threshold during turn-off switches sink to soft current
// - clamp behaviour holds for a fixed hold time before normal sink
// - clamp event sets status bit and, unmasked, pulls fault output low
// - gate sense versus source output mismatch sets status and forces safe state
// - monitor ignores mismatches in programmable blanking after each output edge
// - in two-step shutdown blanking starts only after plateau expiry
// - monitor may be muted during shutdowns, or disabled entirely
// - threshold measure closes switch, charges, waits, samples adc, stores result
// - both pwm inputs pass a programmable deglitch filter
// - without override or a high safe level, output high only with positive high and dead time after negative low
// - both pwm inputs high flags shoot-through, status, fault, forced state
// - zero dead time and negative held low makes output follow positive
// - override enable forces output to override state input level
// - isolated-side override selection uses analog inputs five and six
// - miller clamp engages when source output falls below selected threshold
// - config selects internal clamp switch or external clamp transistor drive
// - faults recorded in readable status register, may assert fault output
package gate_drive_pkg;
   localparam int CLK_MHZ = 125;
   localparam int CLAMP_HOLD_NS = 2000; // fixed clamp hold time
   localparam int CLAMP_HOLD_CYC = (CLAMP_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int THR_DELAY_NS = 4000; // threshold sample delay
   localparam int THR_DELAY_CYC = (THR_DELAY_NS * CLK_MHZ + 999) / 1000;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_TIME0  = 8'h04;
   localparam logic [7:0] ADDR_TIME1  = 8'h08;
   localparam logic [7:0] ADDR_LEVEL  = 8'h0C;
   localparam logic [7:0] ADDR_MASK   = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_ADC    = 8'h18;
   // control bit positions
   localparam int C_TWO_STEP = 0;
   localparam int C_STO_OC   = 1;
   localparam int C_STO_DS   = 2;
   localparam int C_STO_CUR  = 3;
   localparam int C_MON_MUTE = 4;
   localparam int C_MON_OFF  = 5;
   localparam int C_THR_EN   = 6;
   localparam int C_ISO_OVR  = 7;
   localparam int C_EXT_CLMP = 8;
   localparam int C_SAFE_LVL = 9;
   // status and mask bit positions
   localparam int S_SATURATION_SENSE = 0;
   localparam int S_OCSC  = 1;
   localparam int S_CLAMP = 2;
   localparam int S_GMON  = 3;
   localparam int S_SHOOT = 4;
   localparam int S_THR   = 5;
   localparam int NSTAT   = 6;
   // reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] TIME0_RST = 32'h0010_0004;
   localparam logic [31:0] TIME1_RST = 32'h0008_0008;
   localparam logic [31:0] LEVEL_RST = 32'h0000_0484;
   localparam logic [NSTAT-1:0] MASK_RST = 6'h00;
   // sink drive strength codes
   typedef enum logic [1:0] {
      SINK_OFF    = 2'b00,
      SINK_NORMAL = 2'b01,
      SINK_SOFT   = 2'b10,
      SINK_PLAT   = 2'b11
   } sink_mode_e;
   typedef enum logic [1:0] {
      SD_IDLE  = 2'b00,
      SD_PLAT  = 2'b01,
      SD_DISCH = 2'b10
   } shut_state_e;
   typedef enum logic [1:0] {
      TM_IDLE   = 2'b00,
      TM_CHARGE = 2'b01,
      TM_DONE   = 2'b10
   } thr_state_e;
endpackage

// ===== design/gate_drive_protection_control.sv
// gate driver output control with fault shutdown and protections
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module gate_drive_protection_control
   import gate_drive_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        ce_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // pins from outside the clock domain
   input  wire logic        pwm_pos_i,
   input  wire logic        pwm_neg_i,
   input  wire logic        override_enable_i,
   input  wire logic        override_state_input_i,
   input  wire logic        analog_input_five_i,
   input  wire logic        analog_input_six_i,
   input  wire logic        saturation_sense_fault_i,
   input  wire logic        overcurrent_shortcircuit_protect_i,
   input  wire logic        clamp_sense_input_i,
   input  wire logic        gate_sense_i,
   input  wire logic        miller_below_i,
   input  wire logic        adc_ready_i,
   input  wire logic [9:0]  adc_data_i,
   // outputs
   output logic             gate_source_output_o,
   output logic [1:0]       gate_sink_output_o,
   output logic [7:0]       sink_level_o,
   output logic [7:0]       plateau_level_o,
   output logic [1:0]       miller_engage_threshold_o,
   output logic             miller_int_o,
   output logic             miller_ext_o,
   output logic             thr_switch_o,
   output logic             thr_charge_o,
   output logic             adc_start_o,
   output logic             fault_output_n_o
);
   localparam int NSYNC = 22;
   logic [31:0] ctrl_reg, time0_reg, time1_reg, level_reg;
   logic [NSTAT-1:0] mask_reg, status_reg, status_next;
   logic [9:0]  adc_reg;
   logic [NSYNC-1:0] s1_reg, s2_reg, pin;
   logic        pos_dg_reg, neg_dg_reg;
   logic [CNT_W-1:0] pos_cnt_reg, neg_cnt_reg, dead_cnt_reg;
   logic [CNT_W-1:0] plat_cnt_reg, blank_cnt_reg, hold_cnt_reg;
   logic [CNT_W-1:0] thr_cnt_reg;
   shut_state_e sd_reg;
   thr_state_e  tm_reg;
   logic        soft_sel_reg, latched_reg, clamp_act_reg, adc_prev_reg;
   logic        gate_cmd, prev_src_reg, wr, rd;
   logic        ovr_en, ovr_st, fault_ev, shoot, gmon_ev, clamp_ev;

   // two-flop synchronisers for every pin input, adc word and ready too
   assign pin = {adc_data_i, adc_ready_i, pwm_pos_i, pwm_neg_i,
                 override_enable_i, override_state_input_i, analog_input_five_i,
                 analog_input_six_i, saturation_sense_fault_i,
                 overcurrent_shortcircuit_protect_i, clamp_sense_input_i,
                 gate_sense_i, miller_below_i};
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         adc_prev_reg <= 1'b0;
      end else if (ce_i) begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         adc_prev_reg <= s2_reg[11]; // edge finder for adc ready
      end
   end
   wire p_pos = s2_reg[10];
   wire p_neg = s2_reg[9];
   wire p_saturation_sense = s2_reg[4];
   wire p_ocsc = s2_reg[3];
   wire p_clamp = s2_reg[2];
   wire p_gate = s2_reg[1];
   wire p_mill = s2_reg[0];
   wire [9:0] p_adc_data = s2_reg[21:12]; // held while ready stands

   // configuration fields
   wire [CNT_W-1:0] deglitch_len = time0_reg[CNT_W-1:0];
   wire [CNT_W-1:0] dead_len     = time0_reg[31:16];
   wire [CNT_W-1:0] plateau_duration = time1_reg[CNT_W-1:0];
   wire [CNT_W-1:0] blank_len    = time1_reg[31:16];

   // apb strobes: zero wait state, unmapped addresses answer slverr
   assign wr = psel_i && penable_i && pwrite_i;
   assign rd = psel_i && !penable_i && !pwrite_i;
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= ADDR_ADC) && (a[1:0] == 2'b00);
   endfunction

   // software registers
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ctrl_reg  <= CTRL_RST;
         time0_reg <= TIME0_RST;
         time1_reg <= TIME1_RST;
         level_reg <= LEVEL_RST;
         mask_reg  <= MASK_RST;
      end else if (ce_i && wr) begin
         unique case (paddr_i)
            ADDR_CTRL:  ctrl_reg  <= pwdata_i;
            ADDR_TIME0: time0_reg <= pwdata_i;
            ADDR_TIME1: time1_reg <= pwdata_i;
            ADDR_LEVEL: level_reg <= pwdata_i;
            ADDR_MASK:  mask_reg  <= pwdata_i[NSTAT-1:0];
            default: ;
         endcase
      end
   end

   // read data and ready, registered; status write-one-to-clear
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else if (ce_i) begin
         pready_o  <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !mapped(paddr_i);
         if (rd) begin
            unique case (paddr_i)
               ADDR_CTRL:   prdata_o <= ctrl_reg;
               ADDR_TIME0:  prdata_o <= time0_reg;
               ADDR_TIME1:  prdata_o <= time1_reg;
               ADDR_LEVEL:  prdata_o <= level_reg;
               ADDR_MASK:   prdata_o <= {26'h0, mask_reg};
               ADDR_STATUS: prdata_o <= {26'h0, status_reg};
               ADDR_ADC:    prdata_o <= {22'h0, adc_reg};
               default:     prdata_o <= '0;
            endcase
         end
      end
   end

   // input deglitch: level must be stable for deglitch_len + 1 cycles
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pos_dg_reg  <= 1'b0;
         neg_dg_reg  <= 1'b0;
         pos_cnt_reg <= '0;
         neg_cnt_reg <= '0;
      end else if (ce_i) begin
         if (p_pos == pos_dg_reg) pos_cnt_reg <= '0;
         else if (pos_cnt_reg >= deglitch_len) begin
            pos_dg_reg  <= p_pos;
            pos_cnt_reg <= '0;
         end else pos_cnt_reg <= pos_cnt_reg + 1'b1;
         if (p_neg == neg_dg_reg) neg_cnt_reg <= '0;
         else if (neg_cnt_reg >= deglitch_len) begin
            neg_dg_reg  <= p_neg;
            neg_cnt_reg <= '0;
         end else neg_cnt_reg <= neg_cnt_reg + 1'b1;
      end
   end

   // dead time counter since the negative input went low
   always_ff @(posedge clk_i) begin
      if (!nrst_i) dead_cnt_reg <= '0;
      else if (ce_i) begin
         if (neg_dg_reg) dead_cnt_reg <= '0;
         else if (dead_cnt_reg < dead_len)
            dead_cnt_reg <= dead_cnt_reg + 1'b1;
      end
   end

   // shoot-through and override selection
   assign shoot = pos_dg_reg && neg_dg_reg;
   assign ovr_en = ctrl_reg[C_ISO_OVR] ? s2_reg[6] : s2_reg[8];
   assign ovr_st = ctrl_reg[C_ISO_OVR] ? s2_reg[5] : s2_reg[7];
   assign fault_ev = p_saturation_sense || p_ocsc;

   // pwm command: zero dead time with negative low just follows positive
   always_comb begin
      gate_cmd = pos_dg_reg && !neg_dg_reg
                 && (dead_cnt_reg >= dead_len);
   end

   // shutdown sequencer: plateau then discharge, latched until faults clear and the pwm command is low
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sd_reg       <= SD_IDLE;
         plat_cnt_reg <= '0;
         soft_sel_reg <= 1'b0;
      end else if (ce_i) begin
         unique case (sd_reg)
            SD_IDLE: if (fault_ev) begin
               soft_sel_reg <= (p_saturation_sense && ctrl_reg[C_STO_DS])
                            || (p_ocsc && ctrl_reg[C_STO_OC]);
               plat_cnt_reg <= '0;
               sd_reg <= ctrl_reg[C_TWO_STEP] ? SD_PLAT : SD_DISCH;
            end
            SD_PLAT: begin
               if (plat_cnt_reg + 1'b1 >= plateau_duration) begin
                  sd_reg <= SD_DISCH;
                  soft_sel_reg <= ctrl_reg[C_STO_CUR];
               end
               plat_cnt_reg <= plat_cnt_reg + 1'b1;
            end
            SD_DISCH: if (!fault_ev && !gate_cmd) sd_reg <= SD_IDLE;
            default: sd_reg <= SD_IDLE;
         endcase
      end
   end
   wire plat_exp = (sd_reg == SD_PLAT)
                   && (plat_cnt_reg + 1'b1 >= plateau_duration);

   // active clamp hold timer
   assign clamp_ev = p_clamp && !gate_source_output_o && !clamp_act_reg;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         clamp_act_reg <= 1'b0;
         hold_cnt_reg  <= '0;
      end else if (ce_i) begin
         if (clamp_ev) begin
            clamp_act_reg <= 1'b1;
            hold_cnt_reg  <= '0;
         end else if (clamp_act_reg) begin
            if (hold_cnt_reg == CNT_W'(CLAMP_HOLD_CYC - 1))
               clamp_act_reg <= 1'b0;
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
         end
      end
   end

   // gate monitor blanking, restarted by output edges and plateau end
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         blank_cnt_reg <= '0;
         prev_src_reg  <= 1'b0;
      end else if (ce_i) begin
         prev_src_reg <= gate_source_output_o;
         if (((prev_src_reg != gate_source_output_o)
              && sd_reg != SD_PLAT) || plat_exp)
            blank_cnt_reg <= blank_len;
         else if (sd_reg == SD_PLAT)
            blank_cnt_reg <= blank_len;
         else if (blank_cnt_reg != '0)
            blank_cnt_reg <= blank_cnt_reg - 1'b1;
      end
   end
   assign gmon_ev = !ctrl_reg[C_MON_OFF] && (blank_cnt_reg == '0)
                    && !(ctrl_reg[C_MON_MUTE] && sd_reg != SD_IDLE)
                    && (p_gate != prev_src_reg);

   // forced safe state latch for monitor and shoot-through faults
   always_ff @(posedge clk_i) begin
      if (!nrst_i) latched_reg <= 1'b0;
      else if (ce_i) begin
         if (gmon_ev || shoot) latched_reg <= 1'b1;
         else if (!pos_dg_reg && !neg_dg_reg) latched_reg <= 1'b0;
      end
   end

   // threshold measurement sequence
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tm_reg      <= TM_IDLE;
         thr_cnt_reg <= '0;
         adc_reg     <= '0;
         adc_start_o <= 1'b0;
      end else if (ce_i) begin
         adc_start_o <= 1'b0;
         unique case (tm_reg)
            TM_IDLE: if (ctrl_reg[C_THR_EN]) begin
               tm_reg <= TM_CHARGE;
               thr_cnt_reg <= '0;
            end
            TM_CHARGE: begin
               thr_cnt_reg <= thr_cnt_reg + 1'b1;
               if (thr_cnt_reg == CNT_W'(THR_DELAY_CYC - 1)) begin
                  adc_start_o <= 1'b1;
                  tm_reg <= TM_DONE;
               end
            end
            TM_DONE: begin
               if (s2_reg[11] && !adc_prev_reg) adc_reg <= p_adc_data;
               if (!ctrl_reg[C_THR_EN]) tm_reg <= TM_IDLE;
            end
            default: tm_reg <= TM_IDLE;
         endcase
      end
   end

   // sticky status, set wins over write-one-to-clear
   always_comb begin
      status_next = status_reg;
      if (wr && paddr_i == ADDR_STATUS)
         status_next = status_reg & ~pwdata_i[NSTAT-1:0];
      status_next[S_SATURATION_SENSE] = status_next[S_SATURATION_SENSE] | p_saturation_sense;
      status_next[S_OCSC]  = status_next[S_OCSC] | p_ocsc;
      status_next[S_CLAMP] = status_next[S_CLAMP] | clamp_ev;
      status_next[S_GMON]  = status_next[S_GMON] | gmon_ev;
      status_next[S_SHOOT] = status_next[S_SHOOT] | shoot;
      status_next[S_THR]   = status_next[S_THR] | (tm_reg == TM_DONE);
   end
   always_ff @(posedge clk_i) begin
      if (!nrst_i) status_reg <= '0;
      else if (ce_i) status_reg <= status_next;
   end

   // output stage: override beats everything, then faults, then pwm
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         gate_source_output_o <= 1'b0;
         gate_sink_output_o   <= SINK_NORMAL;
         thr_switch_o         <= 1'b0;
         thr_charge_o         <= 1'b0;
      end else if (ce_i) begin
         thr_switch_o <= tm_reg == TM_CHARGE;
         thr_charge_o <= tm_reg == TM_CHARGE;
         if (ovr_en) begin
            gate_source_output_o <= ovr_st;
            gate_sink_output_o   <= ovr_st ? SINK_OFF : SINK_NORMAL;
         end else if (sd_reg == SD_PLAT) begin
            gate_source_output_o <= 1'b0;
            gate_sink_output_o   <= SINK_PLAT;
         end else if (sd_reg == SD_DISCH || fault_ev) begin
            gate_source_output_o <= 1'b0;
            gate_sink_output_o   <= soft_sel_reg ? SINK_SOFT
                                                 : SINK_NORMAL;
         end else if (latched_reg) begin
            gate_source_output_o <= ctrl_reg[C_SAFE_LVL];
            gate_sink_output_o   <= ctrl_reg[C_SAFE_LVL] ? SINK_OFF
                                                         : SINK_NORMAL;
         end else if (gate_cmd) begin
            gate_source_output_o <= 1'b1;
            gate_sink_output_o   <= SINK_OFF;
         end else begin
            gate_source_output_o <= 1'b0;
            gate_sink_output_o   <= clamp_act_reg ? SINK_SOFT
                                                  : SINK_NORMAL;
         end
      end
   end

   // level settings, miller clamp and fault pin
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sink_level_o    <= '0;
         plateau_level_o <= '0;
         miller_engage_threshold_o <= '0;
         miller_int_o    <= 1'b0;
         miller_ext_o    <= 1'b0;
         fault_output_n_o <= 1'b1;
      end else if (ce_i) begin
         sink_level_o    <= level_reg[7:0];
         plateau_level_o <= level_reg[15:8];
         miller_engage_threshold_o <= level_reg[17:16];
         miller_int_o <= p_mill && !gate_source_output_o
                         && !ctrl_reg[C_EXT_CLMP];
         miller_ext_o <= p_mill && !gate_source_output_o
                         && ctrl_reg[C_EXT_CLMP];
         fault_output_n_o <= ~|(status_next & ~mask_reg);
      end
   end

   // checks
   AST_OVERRIDE: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ce_i && ovr_en |=> gate_source_output_o == $past(ovr_st))
      else $error("override not followed");
   AST_SHOOT: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ce_i && shoot |=> status_reg[S_SHOOT])
      else $error("shoot status missing");
   AST_FAULT_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ce_i && fault_ev && !ovr_en |=> !gate_source_output_o)
      else $error("fault did not turn off");
   AST_PLAT: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ce_i && sd_reg == SD_PLAT && !ovr_en
      |=> gate_sink_output_o == SINK_PLAT)
      else $error("plateau drive missing");
   AST_MASK: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ce_i && (status_next & ~mask_reg) != '0 |=> !fault_output_n_o)
      else $error("unmasked fault not reported");
   AST_CLAMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ce_i && clamp_ev |=> clamp_act_reg && status_reg[S_CLAMP])
      else $error("clamp not latched");
   AST_GMON: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ctrl_reg[C_MON_OFF] |-> !gmon_ev)
      else $error("monitor not disabled");
   AST_DEAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      gate_cmd |-> pos_dg_reg && !neg_dg_reg)
      else $error("output high without pwm");
   COV_TWO: cover property (@(posedge clk_i)
      sd_reg == SD_PLAT ##1 sd_reg == SD_DISCH);
   COV_SHOOT: cover property (@(posedge clk_i) shoot);
   COV_THR: cover property (@(posedge clk_i) adc_start_o);
endmodule
`default_nettype wire

// ===== testbench/gate_plant_model.sv
// behavioural power switch and isolated adc seen from the driver pins
`timescale 1ns/100ps
`default_nettype none
module gate_plant_model #(
   parameter logic [9:0] ADC_VAL = 10'h155
) (
   input  wire logic       clk_i,
   input  wire logic       gate_on_i,
   input  wire logic       adc_start_i,
   input  wire logic       stuck_i,
   output logic            gate_sense_o,
   output logic            adc_ready_o,
   output logic [9:0]      adc_data_o
);
   logic [3:0] conv_reg = 4'h0;
   logic       flip_reg = 1'b0;
   // sensed gate follows the driven gate one cycle late, stuck shorts it low
   always_ff @(posedge clk_i) begin
      gate_sense_o <= gate_on_i && !stuck_i;
   end
   // a conversion result stands for four cycles after each start pulse
   always_ff @(posedge clk_i) begin
      conv_reg <= {conv_reg[2:0], adc_start_i};
      flip_reg <= ~flip_reg;
   end
   assign adc_ready_o = |conv_reg;
   // bus toggles while no result stands, so a stale sample cannot match
   assign adc_data_o = adc_ready_o ? ADC_VAL : {10{flip_reg}};
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the gate drive protection block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
   mismatches++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
   import gate_drive_pkg::*;
   localparam logic [9:0] ADC_VAL = 10'h2A5;
   logic        clk_i = 0, nrst_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, slvl, plvl;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, sense, aready, src, astart, flt_n;
   logic        pos = 0, neg = 0, oen = 0, ost = 0, ai5 = 0, ai6 = 0;
   logic        saturation_sense = 0, ocsc = 0, clamp = 0, below = 0, stuck = 0;
   logic        m_int, m_ext, t_sw, t_chg;
   logic [9:0]  adata;
   logic [1:0]  sink, mthr;
   int          mismatches = 0, checks_done = 0, cyc = 0;
   always #4 clk_i = ~clk_i;
   gate_drive_protection_control i_gate_drive_protection_control (
      .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .pwm_pos_i(pos), .pwm_neg_i(neg),
      .override_enable_i(oen), .override_state_input_i(ost),
      .analog_input_five_i(ai5), .analog_input_six_i(ai6),
      .saturation_sense_fault_i(saturation_sense),
      .overcurrent_shortcircuit_protect_i(ocsc),
      .clamp_sense_input_i(clamp), .gate_sense_i(sense),
      .miller_below_i(below), .adc_ready_i(aready), .adc_data_i(adata),
      .gate_source_output_o(src), .gate_sink_output_o(sink),
      .sink_level_o(slvl), .plateau_level_o(plvl),
      .miller_engage_threshold_o(mthr), .miller_int_o(m_int),
      .miller_ext_o(m_ext), .thr_switch_o(t_sw), .thr_charge_o(t_chg),
      .adc_start_o(astart), .fault_output_n_o(flt_n));
   gate_plant_model #(.ADC_VAL(ADC_VAL)) i_gate_plant_model (
      .clk_i(clk_i), .gate_on_i(src), .adc_start_i(astart), .stuck_i(stuck),
      .gate_sense_o(sense), .adc_ready_o(aready), .adc_data_o(adata));
   // one apb transfer: setup, then access until pready is seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1 && ++n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK("pready", 1'b1, pready)
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic rchk(input string s, input logic [7:0] a,
                       input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(s, e, rd)
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      wt(8);
      nrst_i <= 1'b1;
      rchk("ctrl", ADDR_CTRL, CTRL_RST);
      rchk("time0", ADDR_TIME0, TIME0_RST);
      rchk("time1", ADDR_TIME1, TIME1_RST);
      rchk("mask", ADDR_MASK, 32'h0);
      rchk("unmapped", 8'h1C, 32'h0);
      `CHK("slverr", 1'b1, err)
      apb(1'b1, ADDR_LEVEL, 32'h0002_3020);
      rchk("level", ADDR_LEVEL, 32'h0002_3020);
      `CHK("plateau lvl", 8'h30, plvl)
      `CHK("miller thr", 2'h2, mthr)
      $display("test regs done");
      neg <= 1'b1;
      wt(20);
      neg <= 1'b0;
      pos <= 1'b1;
      wt(14);
      `CHK("dead time", 1'b0, src)
      wt(26);
      `CHK("out high", 1'b1, src)
      neg <= 1'b1;
      wt(20);
      rchk("status", ADDR_STATUS, 32'h10);
      `CHK("shoot flt", 1'b0, flt_n)
      `CHK("shoot out", 1'b0, src)
      pos <= 1'b0;
      neg <= 1'b0;
      wt(10);
      apb(1'b1, ADDR_STATUS, 32'h3F);
      apb(1'b1, ADDR_MASK, 32'h10);
      apb(1'b1, ADDR_TIME0, 32'h0000_0004);
      `CHK("flt clear", 1'b1, flt_n)
      pos <= 1'b1;
      wt(12);
      `CHK("no dead", 1'b1, src)
      neg <= 1'b1;
      wt(20);
      rchk("masked st", ADDR_STATUS, 32'h10);
      `CHK("masked flt", 1'b1, flt_n)
      neg <= 1'b0;
      pos <= 1'b0;
      wt(10);
      apb(1'b1, ADDR_STATUS, 32'h3F);
      apb(1'b1, ADDR_MASK, 32'h0);
      $display("test pwm done");
      apb(1'b1, ADDR_CTRL, 32'h1);
      pos <= 1'b1;
      wt(20);
      saturation_sense <= 1'b1;
      wt(5);
      `CHK("plateau", SINK_PLAT, sink)
      `CHK("saturation_sense off", 1'b0, src)
      wt(12);
      `CHK("after plat", SINK_NORMAL, sink)
      rchk("saturation_sense st", ADDR_STATUS, 32'h1);
      `CHK("saturation_sense flt", 1'b0, flt_n)
      saturation_sense <= 1'b0;
      pos <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b1, ADDR_STATUS, 32'h3F);
      ocsc <= 1'b1;
      wt(5);
      `CHK("soft sink", SINK_SOFT, sink)
      `CHK("soft lvl", 8'h20, slvl)
      ocsc <= 1'b0;
      rchk("oc st", ADDR_STATUS, 32'h2);
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_STATUS, 32'h3F);
      $display("test shutdown done");
      clamp <= 1'b1;
      wt(6);
      `CHK("clamp sink", SINK_SOFT, sink)
      clamp <= 1'b0;
      wt(200);
      `CHK("clamp hold", SINK_SOFT, sink)
      `CHK("clamp flt", 1'b0, flt_n)
      wt(60);
      `CHK("clamp end", SINK_NORMAL, sink)
      rchk("clamp st", ADDR_STATUS, 32'h4);
      apb(1'b1, ADDR_STATUS, 32'h3F);
      apb(1'b1, ADDR_CTRL, 32'h40);
      wt(5);
      `CHK("thr switch", 1'b1, t_sw)
      `CHK("thr charge", 1'b1, t_chg)
      wt(520);
      rchk("adc", ADDR_ADC, {22'h0, ADC_VAL});
      rchk("thr st", ADDR_STATUS, 32'h20);
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_STATUS, 32'h3F);
      $display("test clamp thr done");
      oen <= 1'b1;
      ost <= 1'b1;
      wt(8);
      `CHK("ovr high", 1'b1, src)
      ost <= 1'b0;
      wt(8);
      `CHK("ovr low", 1'b0, src)
      oen <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h80);
      ai5 <= 1'b1;
      ai6 <= 1'b1;
      wt(8);
      `CHK("iso ovr", 1'b1, src)
      ai5 <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h100);
      below <= 1'b1;
      wt(6);
      `CHK("ext clamp", 1'b1, m_ext)
      `CHK("int idle", 1'b0, m_int)
      apb(1'b1, ADDR_CTRL, 32'h0);
      wt(4);
      `CHK("int clamp", 1'b1, m_int)
      $display("test override miller done");
      pos <= 1'b1;
      wt(20);
      stuck <= 1'b1;
      wt(10);
      `CHK("gmon out", 1'b0, src)
      `CHK("gmon flt", 1'b0, flt_n)
      rchk("gmon st", ADDR_STATUS, 32'h8);
      pos <= 1'b0;
      stuck <= 1'b0;
      wt(10);
      apb(1'b1, ADDR_STATUS, 32'h3F);
      apb(1'b1, ADDR_CTRL, 32'h20);
      pos <= 1'b1;
      wt(20);
      stuck <= 1'b1;
      wt(10);
      `CHK("gmon off out", 1'b1, src)
      rchk("gmon off st", ADDR_STATUS, 32'h0);
      $display("test monitor done");
      stop_test();
   end
endmodule
`default_nettype wire
